// ===== cof_pkg.sv
// shared constants for the counter overflow and mode filter block
// assumes a core that hands in per-counter event pulses and the current mode
package cof_pkg;
  // event selector field positions
  localparam int OF_BIT = 63;
  localparam int MACHINE_COUNT_INHIBIT_BIT = 62;
  localparam int VIRTUAL_USER_COUNT_INHIBIT_BIT = 58;
  localparam int RSV_HI = 57;
  localparam int RSV_LO = 56;
  localparam int NUM_INH = 5;
  // local count overflow interrupt position in pending/enable
  localparam int IRQ_BIT = 13;
  // programmable counter range and shadow width
  localparam int FIRST_CTR = 3;
  localparam int LAST_CTR = 31;
  localparam int NUM_SLOTS = 32;
  localparam logic [31:0] SHADOW_RST = 32'h0000_0000;
  // nominal privilege encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  // register select on the access port
  typedef enum logic [1:0] {
    CSR_COUNTER,
    CSR_EVENT,
    CSR_SHADOW,
    CSR_PENDING
  } cof_csr_e;
endpackage

// ===== cof_filter.sv
// counter overflow detection and privilege mode filtering for the perf counters
// assumes the register access port, events and mode are synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none

// How it works
// - selector holds overflow flag bit 63, five inhibits 62..58, reserved 57..56 kept.
// - a counter does not count while the current mode's inhibit bit is set.
// - with all inhibit bits clear a counter counts in every mode.
// - inhibit bits of unimplemented modes read zero and ignore writes.
// - overflow flag sets on overflow and stays until software writes the selector.
// - overflow is carry out of implemented bits; counter wraps to zero, keeps counting.
// - an interrupt request only comes from an overflow while the flag is zero.
// - software writes of counters or selectors never cause an overflow.
// - the request is local interrupt bit 13 with pending and enable bits.
// - a request sets both the flag and the pending bit.
// - delegation bit chooses supervisor or machine level for the interrupt.
// - with supervisor mode present a read-only shadow of the flags of counters 3 to 31 exists.
// - shadow bit x mirrors the flag of selector x for counters 3 to 31.
// - machine mode reads the shadow ungated.
// - supervisor mode reads shadow bit x only if machine counter enable x set.
// - virtual supervisor needs machine and hypervisor counter enable x both set.
// - virtualization state picks virtual modes or normal modes.
module cof_filter
  import cof_pkg::*;
#(
  parameter int CTR_W = 64,
  parameter int EVT_W = 16,
  parameter bit HAS_S = 1'b1,
  parameter bit HAS_U = 1'b1,
  parameter bit HAS_H = 1'b1
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // current mode and per-counter events
  input wire logic [1:0] priv_mode,
  input wire logic virt_mode,
  input wire logic [NUM_SLOTS-1:0] event_in,
  // counter enables and delegation
  input wire logic [NUM_SLOTS-1:0] mach_counter_en,
  input wire logic [NUM_SLOTS-1:0] hyp_counter_en,
  input wire logic overflow_irq_enable,
  input wire logic overflow_irq_deleg,
  // register access port
  input wire logic csr_we,
  input wire logic csr_re,
  input wire cof_csr_e csr_kind,
  input wire logic [4:0] csr_idx,
  input wire logic [63:0] csr_wdata,
  // read answer
  output logic csr_rvalid,
  output logic [63:0] csr_rdata,
  // interrupt side
  output logic overflow_irq_pending,
  output logic mach_irq,
  output logic sup_irq
);

  typedef struct packed {
    logic [NUM_SLOTS-1:0][CTR_W-1:0] cnt;
    logic [NUM_SLOTS-1:0] overflow_flag;
    logic [NUM_SLOTS-1:0][NUM_INH-1:0] inh;
    logic [NUM_SLOTS-1:0][1:0] reserved_preserve_field;
    logic [NUM_SLOTS-1:0][EVT_W-1:0] evt;
    logic pend;
    logic m_irq;
    logic s_irq;
    logic rvalid;
    logic [63:0] rdata;
  } cof_state_s;

  cof_state_s st_q;
  cof_state_s st_d;

  // inhibit order {m, s, u, vs, vu} matches bits 62 down to 58
  localparam logic [NUM_INH-1:0] IMPL_MASK = {1'b1, HAS_S, HAS_U, HAS_H & HAS_S, HAS_H & HAS_U};

  logic [NUM_INH-1:0] mode_hot;
  logic [NUM_SLOTS-1:0] cnt_wr;
  logic [NUM_SLOTS-1:0] sel_wr;
  logic [NUM_SLOTS-1:0] inh_hit;
  logic [NUM_SLOTS-1:0] count_en;
  logic [NUM_SLOTS-1:0] carry;
  logic [NUM_SLOTS-1:0] ovf;
  logic [NUM_SLOTS-1:0] req;
  logic [NUM_SLOTS-1:0][CTR_W-1:0] inc_val;
  logic [31:0] shadow_true;
  logic [31:0] shadow_view;
  logic [63:0] read_mux;
  logic pend_wr;

  // v=1 selects virtual modes, v=0 the normal ones
  assign mode_hot[4] = !virt_mode && (priv_mode == PRIV_M);
  assign mode_hot[3] = !virt_mode && (priv_mode == PRIV_S);
  assign mode_hot[2] = !virt_mode && (priv_mode == PRIV_U);
  assign mode_hot[1] = virt_mode && (priv_mode == PRIV_S);
  assign mode_hot[0] = virt_mode && (priv_mode == PRIV_U);

  assign pend_wr = csr_we && (csr_kind == CSR_PENDING);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : g_ctr
      localparam bit LIVE = (gi >= FIRST_CTR) && (gi <= LAST_CTR);
      assign cnt_wr[gi] = csr_we && (csr_kind == CSR_COUNTER) && (csr_idx == 5'(gi));
      assign sel_wr[gi] = csr_we && (csr_kind == CSR_EVENT) && (csr_idx == 5'(gi));
      // mode is taken in the same cycle as the event pulse
      assign inh_hit[gi] = |(st_q.inh[gi] & mode_hot);
      // a software write to the counter replaces the increment
      assign count_en[gi] = LIVE && event_in[gi] && !inh_hit[gi] && !cnt_wr[gi];
      // unsigned carry out of the implemented bits
      assign {carry[gi], inc_val[gi]} = {1'b0, st_q.cnt[gi]} + {{CTR_W{1'b0}}, 1'b1};
      assign ovf[gi] = count_en[gi] && carry[gi];
      // only a clear flag lets an overflow raise a request
      assign req[gi] = ovf[gi] && !st_q.overflow_flag[gi];
    end
  endgenerate

  // shadow copies of flags for counters 3..31 only
  assign shadow_true = HAS_S ? (st_q.overflow_flag & 32'hffff_fff8) : SHADOW_RST;

  // gating by reader's mode; user modes see zero
  always_comb
  begin
    shadow_view = SHADOW_RST;
    if (mode_hot[4])
      shadow_view = shadow_true;
    else if (mode_hot[3])
      shadow_view = shadow_true & mach_counter_en;
    else if (mode_hot[1])
      shadow_view = shadow_true & mach_counter_en & hyp_counter_en;
  end

  always_comb
  begin
    read_mux = 64'h0;
    unique case (csr_kind)
      CSR_COUNTER: read_mux = 64'(st_q.cnt[csr_idx]);
      CSR_EVENT:
      begin
        read_mux[OF_BIT] = st_q.overflow_flag[csr_idx];
        read_mux[MACHINE_COUNT_INHIBIT_BIT:VIRTUAL_USER_COUNT_INHIBIT_BIT] = st_q.inh[csr_idx];
        read_mux[RSV_HI:RSV_LO] = st_q.reserved_preserve_field[csr_idx];
        read_mux[EVT_W-1:0] = st_q.evt[csr_idx];
      end
      CSR_SHADOW: read_mux[31:0] = shadow_view;
      CSR_PENDING: read_mux[IRQ_BIT] = st_q.pend;
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    st_d.rvalid = csr_re;
    st_d.rdata = csr_re ? read_mux : st_q.rdata;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (cnt_wr[i])
        st_d.cnt[i] = csr_wdata[CTR_W-1:0];
      else if (count_en[i])
        st_d.cnt[i] = inc_val[i]; // wraps to zero on carry
      if (sel_wr[i])
      begin
        // unimplemented mode inhibits stay zero
        st_d.inh[i] = csr_wdata[MACHINE_COUNT_INHIBIT_BIT:VIRTUAL_USER_COUNT_INHIBIT_BIT] & IMPL_MASK;
        st_d.reserved_preserve_field[i] = csr_wdata[RSV_HI:RSV_LO];
        st_d.evt[i] = csr_wdata[EVT_W-1:0];
      end
      // a same-cycle request beats the software write
      if (sel_wr[i])
        st_d.overflow_flag[i] = csr_wdata[OF_BIT] | req[i];
      else if (req[i])
        st_d.overflow_flag[i] = 1'b1;
    end
    // request raises pending, winning over a software clear
    if (|req)
      st_d.pend = 1'b1;
    else if (pend_wr)
      st_d.pend = csr_wdata[IRQ_BIT];
    // delegated goes to supervisor, else machine
    st_d.m_irq = st_q.pend && overflow_irq_enable && !overflow_irq_deleg;
    st_d.s_irq = st_q.pend && overflow_irq_enable && overflow_irq_deleg;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign csr_rvalid = st_q.rvalid;
  assign csr_rdata = st_q.rdata;
  assign overflow_irq_pending = st_q.pend;
  assign mach_irq = st_q.m_irq;
  assign sup_irq = st_q.s_irq;

  // checks on the flag, counter and interrupt behaviour
  sequence s_pend_up;
    ##1 st_q.pend ##1 (st_q.s_irq || st_q.m_irq || !$past(overflow_irq_enable));
  endsequence

  generate
    for (gi = FIRST_CTR; gi <= LAST_CTR; gi++)
    begin : g_chk
      sequence s_wrap;
        ##1 (st_q.cnt[gi] == '0) && st_q.overflow_flag[gi];
      endsequence

      a_inhibit_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (inh_hit[gi] && !cnt_wr[gi]) |=> $stable(st_q.cnt[gi]))
        else $error("inhibited counter moved");

      a_free_count: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (event_in[gi] && (st_q.inh[gi] == '0) && !cnt_wr[gi])
          |=> st_q.cnt[gi] == $past(st_q.cnt[gi]) + CTR_W'(1))
        else $error("uninhibited counter did not count");

      a_of_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (st_q.overflow_flag[gi] && !sel_wr[gi]) |=> st_q.overflow_flag[gi])
        else $error("overflow flag lost without a write");

      a_wrap_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ovf[gi] && !sel_wr[gi]) |-> s_wrap)
        else $error("counter did not wrap with flag set");

      a_sw_no_ovf: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cnt_wr[gi] |=> (st_q.cnt[gi] == $past(csr_wdata[CTR_W-1:0]))
          && (!$rose(st_q.pend) || $past(|req)))
        else $error("software write treated as overflow");

      a_req_pend: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ovf[gi] && st_q.overflow_flag[gi] && !(|(req)) && !pend_wr)
          |=> $stable(st_q.pend) || !st_q.pend)
        else $error("overflow with flag set raised a request");
    end
  endgenerate

  a_pend_follows: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (|req) |-> s_pend_up)
    else $error("request did not reach pending");

  a_route_level: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st_q.pend && overflow_irq_enable) |=> (st_q.s_irq == $past(overflow_irq_deleg))
      && (st_q.m_irq != $past(overflow_irq_deleg)))
    else $error("interrupt routed to wrong level");

  a_shadow_sup: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (csr_re && csr_kind == CSR_SHADOW && mode_hot[3])
      |=> csr_rvalid && (csr_rdata[31:0] & ~$past(mach_counter_en)) == 32'h0)
    else $error("supervisor shadow read not gated");

  a_inh_unimpl: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st_q.inh[csr_idx] & ~IMPL_MASK) == '0)
    else $error("unimplemented inhibit bit set");

  a_rsv_keep: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (csr_we && csr_kind == CSR_EVENT) |=> st_q.reserved_preserve_field[$past(csr_idx)]
      == $past(csr_wdata[RSV_HI:RSV_LO]))
    else $error("reserved selector bits not kept");

  a_irq_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !overflow_irq_enable |=> !st_q.m_irq && !st_q.s_irq)
    else $error("interrupt raised while disabled");

  a_pend_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (csr_re && csr_kind == CSR_PENDING) |=> csr_rdata[IRQ_BIT] == $past(st_q.pend))
    else $error("pending bit read back wrong");

  a_req_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (|req) |=> (st_q.overflow_flag & $past(req)) == $past(req))
    else $error("request did not set its flag");

  a_shadow_low: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (csr_re && csr_kind == CSR_SHADOW) |=> csr_rdata[FIRST_CTR-1:0] == '0)
    else $error("shadow bits below first counter set");

  a_shadow_mach: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (HAS_S && csr_re && csr_kind == CSR_SHADOW && mode_hot[4])
      |=> csr_rdata[LAST_CTR:FIRST_CTR] == $past(st_q.overflow_flag[LAST_CTR:FIRST_CTR]))
    else $error("machine shadow read was gated");

  a_shadow_virt: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (csr_re && csr_kind == CSR_SHADOW && mode_hot[1])
      |=> (csr_rdata[31:0] & ~($past(mach_counter_en) & $past(hyp_counter_en))) == 32'h0)
    else $error("virtual supervisor shadow read not gated");

endmodule
`default_nettype wire

// ===== cof_core_model.sv
// core side model: drives the current mode and per-counter event pulses
// assumes the bench changes its commands at the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module cof_core_model
(
  // commands from the bench
  input wire logic [2:0] mode_cmd,
  input wire logic [4:0] ev_idx,
  input wire logic ev_fire,
  // core outputs
  output logic [1:0] priv_mode,
  output logic virt_mode,
  output logic [31:0] event_in
);
  assign priv_mode = mode_cmd[1:0];
  assign virt_mode = mode_cmd[2];
  // one event a cycle, so no counter sees two in one edge
  assign event_in = ev_fire ? (32'h1 << ev_idx) : 32'h0;
endmodule
`default_nettype wire

// ===== counter_overflow_mode_filter_tb.sv
// self-checking bench for cof_filter with a behavioural core model
// assumes default parameters: 64-bit counters, all modes implemented
`timescale 1ns/1ps
`default_nettype none
module counter_overflow_mode_filter_tb;
  import cof_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mcmd = 3'h3;
  logic fire = 1'b0;
  logic [1:0] priv;
  logic virt;
  logic [31:0] ev;
  logic [31:0] m_en = 32'h0;
  logic [31:0] h_en = 32'h0;
  logic deleg = 1'b0;
  logic irq_en = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  cof_csr_e kind = CSR_EVENT;
  logic [63:0] wd = 64'h0;
  logic rv;
  logic [63:0] rdat;
  logic pend;
  logic mirq;
  logic sirq;
  logic [63:0] v;
  int miscompares = 0;
  int n_compared = 0;
  always #2 core_clk = ~core_clk;
  cof_core_model core (.mode_cmd(mcmd), .ev_idx(5'h3), .ev_fire(fire), .priv_mode(priv),
    .virt_mode(virt), .event_in(ev));
  cof_filter uut (.core_clk(core_clk), .rst_n(rst_n), .priv_mode(priv), .virt_mode(virt),
    .event_in(ev), .mach_counter_en(m_en), .hyp_counter_en(h_en),
    .overflow_irq_enable(irq_en), .overflow_irq_deleg(deleg), .csr_we(we), .csr_re(re),
    .csr_kind(kind), .csr_idx(5'h3), .csr_wdata(wd), .csr_rvalid(rv), .csr_rdata(rdat),
    .overflow_irq_pending(pend), .mach_irq(mirq), .sup_irq(sirq));
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input cof_csr_e k, input logic [63:0] d);
    @(negedge core_clk);
    kind = k;
    wd = d;
    we = 1'b1;
    @(negedge core_clk);
    we = 1'b0;
  endtask
  task automatic rd(input cof_csr_e k, input string nm, input logic [63:0] e);
    @(negedge core_clk);
    kind = k;
    re = 1'b1;
    @(negedge core_clk);
    re = 1'b0;
    chk("rvalid", 64'h1, {63'h0, rv});
    chk(nm, e, rdat);
  endtask
  // one event in the given mode, mode held only for that edge
  task automatic evt(input logic [2:0] m);
    @(negedge core_clk);
    mcmd = m;
    fire = 1'b1;
    @(negedge core_clk);
    fire = 1'b0;
    mcmd = 3'h3;
  endtask
  task automatic t_fields;
    rd(CSR_EVENT, "sel_rst", 64'h0);
    wr(CSR_EVENT, 64'h7f00_0000_0000_0005);
    rd(CSR_EVENT, "sel_fields", 64'h7f00_0000_0000_0005);
  endtask
  task automatic t_filter;
    wr(CSR_EVENT, 64'h4800_0000_0000_0001);
    wr(CSR_COUNTER, 64'h0);
    evt(3'h3);
    evt(3'h5);
    rd(CSR_COUNTER, "cnt_inh", 64'h0);
    evt(3'h1);
    evt(3'h4);
    rd(CSR_COUNTER, "cnt_ok", 64'h2);
    wr(CSR_EVENT, 64'h1);
    evt(3'h3);
    evt(3'h5);
    rd(CSR_COUNTER, "cnt_all", 64'h4);
  endtask
  task automatic t_ovf;
    wr(CSR_COUNTER, 64'hffff_ffff_ffff_ffff);
    chk("pend_wr", 64'h0, {63'h0, pend});
    evt(3'h3);
    chk("pend_set", 64'h1, {63'h0, pend});
    @(negedge core_clk);
    chk("irq_m", 64'h2, {62'h0, mirq, sirq});
    deleg = 1'b1;
    @(negedge core_clk);
    @(negedge core_clk);
    chk("irq_s", 64'h1, {62'h0, mirq, sirq});
    irq_en = 1'b0;
    @(negedge core_clk);
    chk("irq_off", 64'h0, {62'h0, mirq, sirq});
    irq_en = 1'b1;
    rd(CSR_COUNTER, "cnt_wrap", 64'h0);
    rd(CSR_EVENT, "flag_set", 64'h8000_0000_0000_0001);
    rd(CSR_PENDING, "pend_rd", 64'h2000);
    wr(CSR_PENDING, 64'h0);
    wr(CSR_COUNTER, 64'hffff_ffff_ffff_ffff);
    evt(3'h3);
    chk("pend_again", 64'h0, {63'h0, pend});
    rd(CSR_EVENT, "flag_hold", 64'h8000_0000_0000_0001);
  endtask
  task automatic t_shadow;
    rd(CSR_SHADOW, "shd_m", 64'h8);
    mcmd = 3'h1;
    rd(CSR_SHADOW, "shd_s_off", 64'h0);
    m_en = 32'h8;
    rd(CSR_SHADOW, "shd_s_on", 64'h8);
    mcmd = 3'h5;
    rd(CSR_SHADOW, "shd_vs_off", 64'h0);
    h_en = 32'h8;
    rd(CSR_SHADOW, "shd_vs_on", 64'h8);
    mcmd = 3'h3;
  endtask
  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_fields();
    t_filter();
    t_ovf();
    t_shadow();
    complete_run();
  end
  // guard against a hung run
  initial
  begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
